// ==== verilog/mrs_matrix.sv ====
// Purpose: Multiplicand read-out latches and column shift switch matrix
// Assumes: Inputs come from logic on CLK; words queue in a FIFO
// Notes:   One multiplication runs six column shift cycles of ten
//          primary cycles; rolling enable is given per primary cycle
//
// Contract
// RULE1: Digit read out by counting rolling pulses
// RULE2: Entries start half point after zero, end 10
// RULE3: Carries on index points, pulses on mid points
// RULE4: Roll 9 to 0 sets row latch
// RULE5: All latches clear at point 10
// RULE6: Stop pulse blocks latch set; zero sends none
// RULE7: Stop pulse from window leading edge, 10-14
// RULE8: First column maps positions 1-6 to 6-11
// RULE9: Product position 12 never driven by cells
// RULE10: Each later column shifts mapping down one
// RULE11: One column pulsed, ten pulses, own cycle
// RULE12: Row stays enabled until end of adding
// RULE13: Position k reaches products k through k+5
// RULE14: Cell passes pulse when row and column
// RULE15: Column pulses at 1.5 through 10.5
// RULE16: Ten rolling pulses per cycle while enabled
// RULE17: Cells of one product merge onto one output
// RULE18: Column counter advances on secondary wrap 9-0
`timescale 1ns/1ns
`default_nettype none
`include "mrs_cfg.svh"

module mrs_matrix (
    input wire logic CLK, // 100 MHz clock
    input wire logic SRST, // Synchronous reset, high
    input wire logic CE, // Clock enable, freezes all state
    input wire logic IN_VALID, // Multiplicand word offered
    output logic IN_READY, // FIFO can take the word
    input wire logic [`MRS_WORD_W-1:0] IN_DATA, // Six BCD digits
    input wire logic ROLL_EN, // Add in the next primary cycle
    output mrs_pkg::mrs_prod_t PROD_PULSE, // Entry pulses to product
    output mrs_pkg::mrs_row_t READOUT_LATCH, // Row enables
    output mrs_pkg::mrs_row_t COL_PULSE, // Column pulse, one-hot
    output mrs_pkg::mrs_col_t COL_INDEX, // Column shift cycle number
    output logic BUSY, // Multiplication in progress
    output logic DONE // One-cycle pulse after sixth column
);

    import mrs_pkg::*;

    // Product index that multiplicand row i reaches in column c
    function automatic logic [3:0] prod_index(input logic [2:0] row,
                                              input logic [2:0] col);
        prod_index = {1'b0, row} + `MRS_COL_BASE - {1'b0, col}; // [RULE13]
    endfunction

    // True when an index point lies in an inclusive range
    function automatic logic in_range(input logic [3:0] pt,
                                      input logic [3:0] lo,
                                      input logic [3:0] hi);
        in_range = (pt >= lo) && (pt <= hi);
    endfunction

    mrs_state_t state_r; // Sequencer state
    mrs_state_t state_nxt; // Next sequencer state
    logic [1:0] sub_r; // Clocks within a half point
    logic [4:0] hp_r; // Half-point position in the primary cycle
    logic [3:0] sec_r; // Secondary timer, primary cycles 0..9
    mrs_col_t col_r; // Column shift cycle
    logic add_r; // Current primary cycle adds
    logic late_cycle_window_r; // High over points 10 through 14
    mrs_digit_t digit_r [`MRS_POSITIONS]; // Multiplicand counters
    mrs_row_t readout_latch_r; // Read-out latches
    mrs_prod_t prod_pulse_r; // Registered entry pulses
    mrs_row_t col_pulse_r; // Registered column pulse
    logic done_r; // Registered done pulse
    mrs_prod_t prod_nxt; // Merged cell outputs
    mrs_row_t col_nxt; // Column pulse decode
    logic fifo_valid; // Word waiting
    logic fifo_pop; // Take a word to start
    logic [`MRS_WORD_W-1:0] fifo_data; // Oldest word
    logic tick; // End of a half point
    logic at_int; // Tick on an integer index point
    logic at_mid; // Tick on a mid-index point
    logic [3:0] point; // Index point number
    logic cycle_end; // Last tick of the primary cycle
    logic sec_wrap; // Secondary timer goes 9 to 0
    logic roll_pulse; // Rolling pulse to all counters
    logic stop_pulse_driver; // Point-10 stop pulse
    logic win_now; // Window level for this point
    logic col_strobe; // Column pulse time
    logic run; // Sequencer is running

    assign run = (state_r == MRS_RUN);
    assign tick = CE && run && (sub_r == `MRS_HALF_CLKS - `MRS_SUB_ONE);
    assign point = hp_r[4:1];
    assign at_int = tick && !hp_r[0];
    assign at_mid = tick && hp_r[0];
    assign cycle_end = tick && (hp_r == `MRS_HP_LAST);
    assign sec_wrap = cycle_end && (sec_r == `MRS_SEC_LAST);
    assign fifo_pop = CE && (state_r == MRS_IDLE) && fifo_valid;

    // Ten rolling pulses at points 1..10 on adding cycles
    assign roll_pulse = at_int && add_r && // [RULE16][RULE3]
        in_range(point, `MRS_PT_FIRST_PULSE, `MRS_PT_LAST_PULSE);

    // Window covers 10..14; its rising edge makes the stop pulse
    assign win_now = in_range(point, `MRS_PT_STOP, `MRS_PT_WIN_END);
    assign stop_pulse_driver = at_int && win_now && // [RULE7]
        !late_cycle_window_r;
    // Column pulses at 1.5..10.5, only on adding cycles
    assign col_strobe = at_mid && add_r && // [RULE15][RULE3]
        in_range(point, `MRS_PT_FIRST_PULSE, `MRS_PT_LAST_PULSE);

    // Queue of multiplicand words ahead of the counters
    mrs_fifo #(
        .WIDTH(`MRS_WORD_W),
        .DEPTH(`MRS_FIFO_DEPTH)
    ) u_mrs_fifo (
        .clk(CLK),
        .srst(SRST),
        .ce(CE),
        .in_valid(IN_VALID),
        .in_ready(IN_READY),
        .in_data(IN_DATA),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // Sequencer next state
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            MRS_IDLE:
            begin
                // Start when a word is queued
                if (fifo_valid)
                begin
                    state_nxt = MRS_RUN;
                end
            end
            MRS_RUN:
            begin
                // Finish after the sixth column shift cycle
                if (sec_wrap && (col_r == `MRS_COL_LAST))
                begin
                    state_nxt = MRS_IDLE;
                end
            end
        endcase
    end

    // Sequencer state
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            state_r <= MRS_IDLE;
        end
        else if (CE)
        begin
            state_r <= state_nxt;
        end
    end

    // Half-point prescaler and position in the primary cycle
    always_ff @(posedge CLK)
    begin
        if (SRST || fifo_pop)
        begin
            sub_r <= `MRS_SUB_ZERO;
            hp_r <= `MRS_HP_ZERO;
        end
        else if (CE && run)
        begin
            if (tick)
            begin
                sub_r <= `MRS_SUB_ZERO;
                hp_r <= hp_r + `MRS_HP_ONE; // Wraps at 31 to 0
            end
            else
            begin
                sub_r <= sub_r + `MRS_SUB_ONE;
            end
        end
    end

    // Secondary timer and column shift counter
    always_ff @(posedge CLK)
    begin
        if (SRST || fifo_pop)
        begin
            sec_r <= `MRS_SEC_ZERO;
            col_r <= `MRS_COL_ZERO;
        end
        else if (cycle_end)
        begin
            if (sec_wrap)
            begin
                sec_r <= `MRS_SEC_ZERO;
                col_r <= col_r + `MRS_COL_ONE; // [RULE18]
            end
            else
            begin
                sec_r <= sec_r + `MRS_SEC_ONE;
            end
        end
    end

    // Adding decision taken at the start of each primary cycle
    always_ff @(posedge CLK)
    begin
        if (SRST || fifo_pop)
        begin
            add_r <= 1'b0;
        end
        else if (tick && (hp_r == `MRS_HP_ZERO))
        begin
            // Sampled at point 0 so the whole train sees one value
            add_r <= ROLL_EN;
        end
    end

    // Window level, updated on integer points only
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            late_cycle_window_r <= 1'b0;
        end
        else if (at_int)
        begin
            late_cycle_window_r <= win_now;
        end
    end

    // One counter and one read-out latch per multiplicand position
    genvar gi;
    generate
        for (gi = 0; gi < `MRS_POSITIONS; gi++)
        begin : g_pos
            // Counter rolls through the full decade and ends on its
            // own digit again, so the stored multiplicand survives
            always_ff @(posedge CLK)
            begin
                if (SRST)
                begin
                    digit_r[gi] <= `MRS_DIGIT_ZERO;
                end
                else if (fifo_pop)
                begin
                    digit_r[gi] <= fifo_data[gi*`MRS_DIGIT_W +:
                                             `MRS_DIGIT_W];
                end
                else if (roll_pulse)
                begin
                    if (digit_r[gi] == `MRS_DIGIT_NINE)
                    begin
                        digit_r[gi] <= `MRS_DIGIT_ZERO; // [RULE1]
                    end
                    else
                    begin
                        digit_r[gi] <= digit_r[gi] + 4'h1; // [RULE1]
                    end
                end
            end

            // Stop wins over a carry at 10, so a zero digit never
            // opens its row; the row then holds until the stop
            always_ff @(posedge CLK)
            begin
                if (SRST || fifo_pop)
                begin
                    readout_latch_r[gi] <= 1'b0;
                end
                else if (stop_pulse_driver)
                begin
                    readout_latch_r[gi] <= 1'b0; // [RULE5] [RULE6]
                end
                else if (roll_pulse &&
                         (digit_r[gi] == `MRS_DIGIT_NINE))
                begin
                    readout_latch_r[gi] <= 1'b1; // [RULE4] [RULE12]
                end
            end
        end
    endgenerate

    // Column decode: only the current column is ever pulsed
    always_comb
    begin
        col_nxt = '0;
        if (col_strobe)
        begin
            col_nxt[col_r] = 1'b1; // [RULE11]
        end
    end

    // Switch cells merged per product position
    always_comb
    begin
        prod_nxt = '0;
        for (int i = 0; i < `MRS_POSITIONS; i++) // [RULE17]
        begin
            // Cell is an AND of row latch and column pulse; at most
            // one cell per product conducts, so an OR merges them
            if (readout_latch_r[i] && col_nxt[col_r]) // [RULE14][RULE2]
            begin
                prod_nxt[prod_index(i[2:0], col_r)] = 1'b1; // [RULE8][RULE10]
            end
        end
        // Top product position only gathers carries
        prod_nxt[`MRS_PROD_POSITIONS-1] = 1'b0; // [RULE9]
    end

    // Output registers
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            prod_pulse_r <= '0;
            col_pulse_r <= '0;
            done_r <= 1'b0;
        end
        else if (CE)
        begin
            prod_pulse_r <= prod_nxt;
            col_pulse_r <= col_nxt;
            done_r <= sec_wrap && (col_r == `MRS_COL_LAST);
        end
    end

    assign PROD_PULSE = prod_pulse_r;
    assign COL_PULSE = col_pulse_r;
    assign READOUT_LATCH = readout_latch_r;
    assign COL_INDEX = col_r;
    assign BUSY = (state_r == MRS_RUN);
    assign DONE = done_r;

endmodule // mrs_matrix

`default_nettype wire

// ==== verilog/mrs_cfg.svh ====
// Purpose: Named constants for the multiplicand read-out shift matrix
// Assumes: One clock, one primary cycle split into half index points
// Notes:   Definitions only; included by the package and the top module
`ifndef MRS_CFG_SVH
`define MRS_CFG_SVH

// Datapath shape
`define MRS_POSITIONS 6
`define MRS_PROD_POSITIONS 12
`define MRS_DIGIT_W 4
`define MRS_WORD_W 24
`define MRS_FIFO_DEPTH 16

// Digit values
`define MRS_DIGIT_ZERO 4'h0
`define MRS_DIGIT_NINE 4'h9

// Clocks spent on each half index point
`define MRS_HALF_CLKS 2'h2
`define MRS_SUB_ZERO 2'h0
`define MRS_SUB_ONE 2'h1

// Half-point counter: 16 index points, two halves each
`define MRS_HP_ZERO 5'h00
`define MRS_HP_ONE 5'h01
`define MRS_HP_LAST 5'h1F

// Index points of the primary cycle
`define MRS_PT_FIRST_PULSE 4'h1
`define MRS_PT_LAST_PULSE 4'hA
`define MRS_PT_STOP 4'hA
`define MRS_PT_WIN_END 4'hE

// Secondary timer and column shift counter
`define MRS_SEC_ZERO 4'h0
`define MRS_SEC_LAST 4'h9
`define MRS_SEC_ONE 4'h1
`define MRS_COL_ZERO 3'h0
`define MRS_COL_LAST 3'h5
`define MRS_COL_ONE 3'h1

// Product offset of the first column shift cycle
`define MRS_COL_BASE 4'h5

`endif

// ==== verilog/mrs_pkg.sv ====
// Purpose: Types shared by the read-out shift matrix modules
// Assumes: mrs_cfg.svh supplies the widths
// Notes:   Types only; numbers live in the header
`include "mrs_cfg.svh"

package mrs_pkg;

    // One decimal counter position
    typedef logic [`MRS_DIGIT_W-1:0] mrs_digit_t;

    // Column shift cycle number, 0 for the first column
    typedef logic [2:0] mrs_col_t;

    // Product pulse vector, bit 0 is product position 1
    typedef logic [`MRS_PROD_POSITIONS-1:0] mrs_prod_t;

    // Multiplicand row vector, bit 0 is multiplicand position 1
    typedef logic [`MRS_POSITIONS-1:0] mrs_row_t;

    // Sequencer states
    typedef enum logic [0:0] {
        MRS_IDLE,
        MRS_RUN
    } mrs_state_t;

endpackage

// ==== verilog/mrs_fifo.sv ====
// Purpose: Flop-based FIFO holding queued multiplicand words
// Assumes: Same clock as its user; push and pop may share a cycle
// Notes:   Full and empty come from pointers with one wrap bit
`timescale 1ns/1ns
`default_nettype none

module mrs_fifo #(
    parameter int WIDTH = 24, // Word width
    parameter int DEPTH = 16  // Entries, power of two
) (
    input wire logic clk, // Clock
    input wire logic srst, // Synchronous reset, high
    input wire logic ce, // Clock enable
    input wire logic in_valid, // Word offered
    output logic in_ready, // Room available
    input wire logic [WIDTH-1:0] in_data, // Word in
    output logic out_valid, // Word available
    input wire logic out_ready, // Drain takes word
    output logic [WIDTH-1:0] out_data // Oldest word
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH]; // Storage flops
    logic [AW:0] wr_ptr_r; // Write pointer with wrap bit
    logic [AW:0] rd_ptr_r; // Read pointer with wrap bit
    logic push; // Accepted write
    logic pop; // Accepted read
    logic [AW:0] wr_ptr_nxt; // Write pointer after this edge
    logic [AW:0] rd_ptr_nxt; // Read pointer after this edge
    logic in_ready_r; // Registered room flag

    assign in_ready = in_ready_r;
    assign wr_ptr_nxt = push ? wr_ptr_r + (AW+1)'(1) : wr_ptr_r;
    assign rd_ptr_nxt = pop ? rd_ptr_r + (AW+1)'(1) : rd_ptr_r;
    assign out_valid = (wr_ptr_r != rd_ptr_r);
    assign out_data = mem_r[rd_ptr_r[AW-1:0]];
    assign push = ce && in_valid && in_ready;
    assign pop = ce && out_valid && out_ready;

    // Storage write; no reset needed since empty hides stale data
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end
        else
        begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
        end
    end

    // Room flag kept in a flop so the top's IN_READY is registered; it
    // looks ahead to the pointers this edge loads, so no word is lost.
    // Full when indices match and wrap bits differ.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            in_ready_r <= 1'b1;
        end
        else
        begin
            in_ready_r <= !((wr_ptr_nxt[AW] != rd_ptr_nxt[AW]) &&
                (wr_ptr_nxt[AW-1:0] == rd_ptr_nxt[AW-1:0]));
        end
    end

endmodule // mrs_fifo

`default_nettype wire

// ==== verif/mrs_prod_model.sv ====
// Purpose: Far-side decimal product counter fed by the entry pulses
// Assumes: Pulses are one clock wide and registered by the matrix
// Notes:   Keeps a running decimal sum; carries ripple at once
`timescale 1ns/1ns
`default_nettype none

module mrs_prod_model
    import mrs_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic srst, // Clears the sum
    input wire mrs_pkg::mrs_prod_t pulse, // One line per position
    output var longint acc // Running decimal sum
);
    // Each line adds one unit of its decade; ideal carries, no delay
    always @(posedge clk)
    begin : count_entries
        longint w;
        longint s;
        w = 1;
        s = acc;
        for (int p = 0; p < 12; p++)
        begin
            if (pulse[p] === 1'b1) // Shared line per position
                s = s + w;
            w = w * 10;
        end
        acc <= srst ? 64'sh0 : s;
    end
endmodule // mrs_prod_model

`default_nettype wire

// ==== verif/mrs_matrix_props.sv ====
// Purpose: Port-level checks for the read-out shift matrix
// Assumes: CE is low only while nothing is being pulsed
// Notes:   Bound to every mrs_matrix instance below
`timescale 1ns/1ns
`default_nettype none

module mrs_matrix_props
    import mrs_pkg::*;
(
    input wire logic CLK, // Clock
    input wire logic SRST, // Sync reset
    input wire mrs_pkg::mrs_prod_t PROD_PULSE, // Entry pulses
    input wire mrs_pkg::mrs_row_t READOUT_LATCH, // Row enables
    input wire mrs_pkg::mrs_row_t COL_PULSE, // Column pulses
    input wire mrs_pkg::mrs_col_t COL_INDEX // Column number
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (SRST);

    mrs_prod_t exp_prod; // Pulses implied by rows and active column

    // Row AND column, merged per product position
    always_comb
    begin
        exp_prod = 12'h000;
        for (int i = 0; i < 6; i++)
            if (READOUT_LATCH[i] && COL_PULSE != 6'h00)
                exp_prod[i + 5 - int'(COL_INDEX)] = 1'b1;
    end

    sequence row_set;
        (READOUT_LATCH & ~$past(READOUT_LATCH)) != 6'h00;
    endsequence

    sequence entry_soon;
        ##[1:4] (PROD_PULSE != 12'h000);
    endsequence

    prod_top_idle_a: assert property (PROD_PULSE[11] == 1'b0)
        else $error("top product position driven");
    cell_map_a: assert property
        (PROD_PULSE == exp_prod)
        else $error("entry pulses do not match rows and column");
    col_onehot_a: assert property ($onehot0(COL_PULSE))
        else $error("more than one column pulsed");
    col_sel_a: assert property ((COL_PULSE != 6'h00) |->
        COL_PULSE == (6'h01 << COL_INDEX))
        else $error("pulsed column differs from column index");
    pulse_gap_a: assert property ((COL_PULSE != 6'h00) |=>
        (COL_PULSE == 6'h00) [*3])
        else $error("column pulses closer than one point");
    latch_clear_a: assert property
        ((($past(READOUT_LATCH) & ~READOUT_LATCH) != 6'h00) |->
        READOUT_LATCH == 6'h00)
        else $error("read-out latch cleared alone");
    entry_follow_a: assert property
        (row_set |-> entry_soon)
        else $error("no entry pulse after latch set");
    col_step_a: assert property
        ((COL_INDEX != $past(COL_INDEX)) |->
        (COL_INDEX == $past(COL_INDEX) + 3'h1 || COL_INDEX == 3'h0))
        else $error("column index skipped");
endmodule // mrs_matrix_props

bind mrs_matrix mrs_matrix_props u_mrs_matrix_props (.CLK(CLK),
    .SRST(SRST), .PROD_PULSE(PROD_PULSE), .READOUT_LATCH(READOUT_LATCH),
    .COL_PULSE(COL_PULSE), .COL_INDEX(COL_INDEX));

`default_nettype wire

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the read-out shift matrix
// Assumes: CE dropped once, on a run without adding; inputs change
//          on the falling edge
// Notes:   Partner sums entry pulses as a decimal product
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    import mrs_pkg::*;
    logic clk = 1'b0; // Bench clock
    logic srst = 1'b1; // Reset
    logic ce = 1'b1; // Clock enable
    logic in_valid = 1'b0; // Word offered
    logic [23:0] in_data = 24'h000000; // Word
    logic roll_en = 1'b0; // Adding request
    logic in_ready, busy, done; // Status
    mrs_prod_t prod_pulse; // Entry pulses
    mrs_row_t latch, col_pulse; // Rows and columns
    mrs_col_t col_index; // Column number
    longint acc; // Partner sum
    int fails = 0;
    int tests_run = 0;

    initial forever #5 clk = ~clk;

    mrs_matrix u_mrs_matrix (.CLK(clk), .SRST(srst), .CE(ce),
        .IN_VALID(in_valid), .IN_READY(in_ready), .IN_DATA(in_data),
        .ROLL_EN(roll_en), .PROD_PULSE(prod_pulse), .READOUT_LATCH(latch),
        .COL_PULSE(col_pulse), .COL_INDEX(col_index), .BUSY(busy),
        .DONE(done));
    mrs_prod_model u_mrs_prod_model (.clk(clk), .srst(srst),
        .pulse(prod_pulse), .acc(acc));

    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        tests_run++;
        if (seen !== want)
        begin
            fails++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic wrap_up;
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Counts a hang as a mismatch and ends the run
    task automatic give_up;
        fails++;
        wrap_up();
    endtask

    // Fill until refused, then drain with no adding at all
    task automatic t_fifo;
        int n;
        int dones;
        int k;
        n = 0;
        dones = 0;
        in_data = 24'h999999;
        in_valid = 1'b1;
        for (k = 0; k < 20; k++)
        begin
            if (in_ready === 1'b1)
                n++;
            @(negedge clk);
        end
        in_valid = 1'b0;
        check(n, 17); // One running plus sixteen queued, rest refused
        for (k = 0; k < 66000 && !(dones == 17 && busy === 1'b0); k++)
        begin
            @(negedge clk);
            if (done === 1'b1)
                dones++;
        end
        if (k == 66000)
            give_up();
        check(dones, 17);
        check(acc, 0);
    endtask

    // One full multiplication; adding cycles per column set the digit
    task automatic t_mult;
        int d[6] = '{2, 7, 3, 5, 0, 9}; // Multiplicand, position 1 first
        int m[6] = '{9, 0, 7, 1, 5, 4}; // Adding cycles per column
        longint mv;
        longint nv;
        int k;
        mv = 0;
        nv = 0;
        for (int i = 5; i >= 0; i--)
        begin
            mv = mv * 10 + d[i];
            nv = nv * 10 + m[5 - i];
            in_data[4 * i +: 4] = d[i][3:0];
        end
        roll_en = 1'b1;
        in_valid = 1'b1;
        @(negedge clk);
        in_valid = 1'b0;
        for (k = 0; k < 4 && busy !== 1'b1; k++)
            @(negedge clk);
        if (k == 4)
            give_up();
        // Change the request mid-cycle, far from its sampling point
        repeat (30) @(negedge clk);
        for (int g = 1; g < 60; g++)
        begin
            roll_en = ((g % 10) < m[g / 10]);
            repeat (64) @(negedge clk);
        end
        roll_en = 1'b0;
        for (k = 0; k < 200 && busy !== 1'b0; k++)
            @(negedge clk);
        if (k == 200)
            give_up();
        check(acc, mv * nv);
    endtask

    // Freeze a run without adding: each low-enable clock stretches it,
    // and a frozen column must not reach its next step meanwhile
    task automatic t_ce;
        int k;
        mrs_col_t col_seen;
        col_seen = 3'h0;
        in_valid = 1'b1;
        @(negedge clk);
        in_valid = 1'b0;
        for (k = 0; k < 4 && busy !== 1'b1; k++)
            @(negedge clk);
        if (k == 4)
            give_up();
        for (k = 0; k < 5000 && busy === 1'b1; k++)
        begin
            if (k == 1200)
            begin
                col_seen = col_index;
                ce = 1'b0;
            end
            if (k == 1500)
            begin
                check(col_index, col_seen);
                ce = 1'b1;
            end
            @(negedge clk);
        end
        if (k == 5000)
            give_up();
        check(k, 4140); // 3840 enabled clocks plus 300 frozen
        check(done, 1'b1);
    endtask

    initial
    begin
        repeat (16) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        check({in_ready, busy, latch, prod_pulse}, 20'h80000);
        t_fifo();
        t_mult();
        t_ce();
        wrap_up();
    end
endmodule // tb_top

`default_nettype wire
